// ==== flash_protect_config_tb.sv ====
`timescale 1ns/10ps
module flash_protect_config_tb
   import fpc_pkg::*;
;
   logic mclk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rs, bdoor;
   logic [7:0] nvm;
   logic spec, fwr, frd, cwr, kwr, rgo, creq, cmass, cok, cref, viol, irq, bflag, dflag;
   logic [14:0] caddr;
   int fail_count, checked;
   logic [15:0] seq [7] = '{16'h3F3F, 16'h7F3F, 16'h3E3E, 16'h3F3E, 16'h3B3B, 16'h3939, 16'h3C39};
   logic [14:0] alist [9] = '{15'h03FF, 15'h0400, 15'h07FF, 15'h0800, 15'h0BFF, 15'h0C00, 15'h0FFF, 15'h1000, 15'h7FFF};
   logic [4:0] hlist [4] = '{5'h00, 5'h0F, 5'h1D, 5'h1E};

   // ----------------------------------------
   // clock, design and partner
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   fpc_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .nvm_prot_byte(nvm), .backdoor_enable_field(bdoor), .special_mode(spec),
      .buf_empty_flag(bflag), .cmd_done_flag(dflag), .flash_wr_valid(fwr), .flash_rd_req(frd),
      .cmd_wr_pulse(cwr), .key_wr_pulse(kwr), .flash_rd_go(rgo), .cmd_req(creq), .cmd_mass(cmass),
      .cmd_addr(caddr), .cmd_ok(cok), .cmd_refused(cref), .protect_violation_flag(viol), .flash_irq(irq));
   fpc_cpu_model u_cpu (.mclk(mclk), .flash_wr_valid(fwr), .flash_rd_req(frd), .cmd_req(creq),
      .cmd_mass(cmass), .cmd_addr(caddr), .buf_empty_flag(bflag), .cmd_done_flag(dflag));

   // ----------------------------------------
   // bus tasks and checks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // address and data offered together, each dropped at its own handshake edge
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ap, wp, ha, hw;
      ap = 1'b1;
      wp = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (ap || wp) begin
         @(negedge mclk);
         ha = ap && (awready === 1'b1);
         hw = wp && (wready === 1'b1);
         @(posedge mclk);
         if (ha) begin
            awvalid <= 1'b0;
            ap = 1'b0;
         end
         if (hw) begin
            wvalid <= 1'b0;
            wp = 1'b0;
         end
      end
      do @(negedge mclk); while (bvalid !== 1'b1);
      r = bresp;
      @(posedge mclk);
      bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge mclk); while (arready !== 1'b1);
      @(posedge mclk);
      arvalid <= 1'b0;
      do @(negedge mclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge mclk);
      rready <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      axi_write(a, d, rs);
      check({30'h0, rs}, {30'h0, FPC_RESP_OKAY});
   endtask
   task automatic rd_check(input logic [11:0] a, input logic [31:0] exp);
      axi_read(a, rd, rs);
      check(rd, exp);
   endtask
   // protection set freely through special mode
   task automatic set_prot(input logic [7:0] p);
      spec <= 1'b1;
      wr(FPC_PROT_OFS, {24'h0, p});
      spec <= 1'b0;
   endtask
   // expected protection of one array offset, reserved lower codes covering everything
   function automatic logic prot_hit(input logic [7:0] p, input logic [14:0] a);
      logic [15:0] lim;
      case (p[2:0])
         3'h3: lim = 16'h1000;
         3'h4: lim = 16'h0C00;
         3'h5: lim = 16'h0800;
         3'h6: lim = 16'h0400;
         3'h7: lim = 16'h0000;
         default: lim = 16'h8000;
      endcase
      return ((p[7:3] != FPC_HI_NONE) && (a[14:10] > p[7:3])) || ({1'b0, a} < lim);
   endfunction
   task automatic try_cmd(input logic [14:0] a, input logic m, input logic refuse);
      u_cpu.issue(a, m);
      #1;
      check({30'h0, cref, cok}, refuse ? 32'h2 : 32'h1);
      @(posedge mclk);
   endtask
   task automatic try_arr(input logic w, input logic [2:0] exp);
      u_cpu.pulse(w);
      #1;
      check({29'h0, kwr, cwr, rgo}, {29'h0, exp});
      @(posedge mclk);
   endtask
   task automatic irq_check(input logic exp);
      repeat (3) @(posedge mclk);
      #1;
      check({31'h0, irq}, {31'h0, exp});
      @(posedge mclk);
   endtask
   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ----------------------------------------
   // watchdog: the tests need well under a thousand cycles
   // ----------------------------------------
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      end_sim();
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, spec} = '0;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h0;
      bdoor = 2'h0;
      // stored byte as software left it after reprogramming the config sector
      nvm = 8'h7F;
      sys_rst = 1'b1;
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      rd_check(FPC_PROT_OFS, 32'h7F);
      rd_check(FPC_CFG_OFS, 32'h0);
      axi_read(12'h200, rd, rs);
      check({rd[29:0], rs}, {30'h0, FPC_RESP_SLVERR});
      axi_write(12'h200, 32'hFF, rs);
      check({30'h0, rs}, {30'h0, FPC_RESP_SLVERR});
      $display("test reset and map done");
      wr(FPC_CFG_OFS, 32'hFF);
      rd_check(FPC_CFG_OFS, 32'hC0);
      wr(FPC_CFG_OFS, 32'h0);
      bdoor <= FPC_KEY_ENABLED;
      wr(FPC_CFG_OFS, 32'hFF);
      rd_check(FPC_CFG_OFS, 32'hE0);
      try_arr(1'b1, 3'h4);
      try_arr(1'b0, 3'h1);
      wr(FPC_CFG_OFS, 32'h0);
      try_arr(1'b1, 3'h2);
      $display("test config and key done");
      foreach (seq[i]) begin
         wr(FPC_PROT_OFS, {24'h0, seq[i][15:8]});
         rd_check(FPC_PROT_OFS, {24'h0, seq[i][7:0]});
      end
      set_prot(8'hFF);
      rd_check(FPC_PROT_OFS, 32'hFF);
      $display("test protection writes done");
      for (int c = 0; c < 8; c++) begin
         set_prot({5'h1F, c[2:0]});
         foreach (alist[j]) try_cmd(alist[j], 1'b0, prot_hit({5'h1F, c[2:0]}, alist[j]));
         try_cmd(15'h0000, 1'b1, c != 7);
      end
      foreach (hlist[k]) begin
         set_prot({hlist[k], 3'h6});
         for (int m = -1; m < 1; m++) try_cmd(15'(({10'h0, hlist[k]} + 1) * 1024 + m), 1'b0,
            prot_hit({hlist[k], 3'h6}, 15'(({10'h0, hlist[k]} + 1) * 1024 + m)));
         try_cmd(15'h7FFF, 1'b0, 1'b1);
         try_cmd(15'h0000, 1'b1, 1'b1);
      end
      check({31'h0, viol}, 32'h1);
      rd_check(FPC_STAT_OFS, 32'h20);
      wr(FPC_STAT_OFS, 32'h20);
      check({31'h0, viol}, 32'h0);
      $display("test range decode done");
      u_cpu.set_flags(1'b1, 1'b1);
      irq_check(1'b0);
      wr(FPC_CFG_OFS, 32'h80);
      irq_check(1'b1);
      wr(FPC_CFG_OFS, 32'h40);
      irq_check(1'b1);
      u_cpu.set_flags(1'b1, 1'b0);
      irq_check(1'b0);
      wr(FPC_CFG_OFS, 32'h0);
      u_cpu.set_flags(1'b0, 1'b0);
      axi_read(FPC_IRQ_STAT_OFS, rd, rs);
      wr(FPC_IRQ_MASK_OFS, 32'h4);
      rd_check(FPC_IRQ_MASK_OFS, 32'h4);
      try_cmd(15'h0000, 1'b0, 1'b1);
      irq_check(1'b1);
      rd_check(FPC_IRQ_STAT_OFS, 32'h4);
      irq_check(1'b0);
      rd_check(FPC_IRQ_STAT_OFS, 32'h0);
      $display("test interrupts done");
      // second reset in mid-run: protection reloads from a new stored byte
      nvm <= 8'hF5;
      sys_rst <= 1'b1;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      rd_check(FPC_PROT_OFS, 32'hF5);
      rd_check(FPC_CFG_OFS, 32'h0);
      check({31'h0, viol}, 32'h0);
      $display("test second reset done");
      end_sim();
   end
endmodule

// ==== fpc_cpu_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// cpu and command engine side of the array
// ----------------------------------------
module fpc_cpu_model (
   // clock
   input wire logic mclk,
   // array accesses
   output logic flash_wr_valid,
   output logic flash_rd_req,
   // program and erase requests
   output logic cmd_req,
   output logic cmd_mass,
   output logic [14:0] cmd_addr,
   // engine flags
   output logic buf_empty_flag,
   output logic cmd_done_flag
);
   initial begin
      flash_wr_valid = 1'b0;
      flash_rd_req = 1'b0;
      cmd_req = 1'b0;
      cmd_mass = 1'b0;
      cmd_addr = 15'h0000;
      buf_empty_flag = 1'b0;
      cmd_done_flag = 1'b0;
   end
   // one-cycle array write or read, called right after a rising edge
   task automatic pulse(input logic wr);
      if (wr) flash_wr_valid <= 1'b1;
      else flash_rd_req <= 1'b1;
      @(posedge mclk);
      flash_wr_valid <= 1'b0;
      flash_rd_req <= 1'b0;
   endtask
   // request is one cycle; address inverted afterwards so a stale value never looks valid
   task automatic issue(input logic [14:0] a, input logic m);
      cmd_req <= 1'b1;
      cmd_addr <= a;
      cmd_mass <= m;
      @(posedge mclk);
      cmd_req <= 1'b0;
      cmd_addr <= ~a;
      cmd_mass <= ~m;
   endtask
   // flags are levels held by the engine
   task automatic set_flags(input logic b, input logic c);
      buf_empty_flag <= b;
      cmd_done_flag <= c;
   endtask
endmodule

// ==== fpc_pkg.sv ====
package fpc_pkg;

   // ----------------------------------------
   // register byte addresses
   // ----------------------------------------
   localparam logic [11:0] FPC_PROT_OFS = 12'h104;
   localparam logic [11:0] FPC_CFG_OFS = 12'h108;
   localparam logic [11:0] FPC_STAT_OFS = 12'h10C;
   localparam logic [11:0] FPC_IRQ_STAT_OFS = 12'h110;
   localparam logic [11:0] FPC_IRQ_MASK_OFS = 12'h114;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int FPC_CFG_BUF_IE_BIT = 7;
   localparam int FPC_CFG_DONE_IE_BIT = 6;
   localparam int FPC_CFG_KEY_BIT = 5;
   localparam int FPC_HI_MSB = 7;
   localparam int FPC_HI_LSB = 3;
   localparam int FPC_LO_MSB = 2;
   localparam int FPC_LO_LSB = 0;
   localparam int FPC_STAT_VIOL_BIT = 5;
   localparam int FPC_EVT_BUF_BIT = 0;
   localparam int FPC_EVT_DONE_BIT = 1;
   localparam int FPC_EVT_VIOL_BIT = 2;
   localparam int FPC_EVT_W = 3;

   // ----------------------------------------
   // codes and reset values
   // ----------------------------------------
   localparam logic [4:0] FPC_HI_NONE = 5'h1F;
   localparam logic [2:0] FPC_LO_NONE = 3'h7;
   localparam logic [1:0] FPC_KEY_ENABLED = 2'h2;
   localparam logic [7:0] FPC_CFG_RST = 8'h00;
   localparam logic [FPC_EVT_W-1:0] FPC_MASK_RST = 3'h0;
   localparam logic [1:0] FPC_RESP_OKAY = 2'h0;
   localparam logic [1:0] FPC_RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // flash array geometry
   // ----------------------------------------
   localparam int FPC_ADDR_W = 15;
   localparam int FPC_SECTOR_LSB = 10;

endpackage

// ==== fpc_prot_check.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// protection range decoder
// ----------------------------------------
module fpc_prot_check
   import fpc_pkg::*;
(
   // protection setting
   input wire logic [7:0] prot,
   // address under test
   input wire logic [FPC_ADDR_W-1:0] addr,
   // results
   output logic hit,
   output logic any_prot
);

   logic [4:0] hi_code;
   logic [2:0] lo_code;
   logic [4:0] kb;
   logic hi_hit;
   logic lo_hit;

   assign hi_code = prot[FPC_HI_MSB:FPC_HI_LSB];
   assign lo_code = prot[FPC_LO_MSB:FPC_LO_LSB];
   assign kb = addr[FPC_ADDR_W-1:FPC_SECTOR_LSB];

   // higher range starts at (code+1) kbytes and runs to the top
   assign hi_hit = (hi_code != FPC_HI_NONE) && (kb > hi_code);

   // lower range from the base; reserved codes fall back to whole array
   always_comb begin
      case (lo_code)
         3'h3: lo_hit = (kb < 5'h04);
         3'h4: lo_hit = (kb < 5'h03);
         3'h5: lo_hit = (kb < 5'h02);
         3'h6: lo_hit = (kb < 5'h01);
         3'h7: lo_hit = 1'b0;
         default: lo_hit = 1'b1;
      endcase
   end

   // both ranges checked side by side
   assign hit = hi_hit | lo_hit;
   assign any_prot = (hi_code != FPC_HI_NONE) || (lo_code != FPC_LO_NONE);

endmodule

// ==== fpc_top.sv ====
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
module fpc_top
   import fpc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // axi4-lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // axi4-lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // axi4-lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // axi4-lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // axi4-lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // configuration field and mode
   input wire logic [7:0] nvm_prot_byte,
   input wire logic [1:0] backdoor_enable_field,
   input wire logic special_mode,
   // command engine flags
   input wire logic buf_empty_flag,
   input wire logic cmd_done_flag,
   // array write and read requests
   input wire logic flash_wr_valid,
   input wire logic flash_rd_req,
   output logic cmd_wr_pulse,
   output logic key_wr_pulse,
   output logic flash_rd_go,
   // program and erase check
   input wire logic cmd_req,
   input wire logic cmd_mass,
   input wire logic [FPC_ADDR_W-1:0] cmd_addr,
   output logic cmd_ok,
   output logic cmd_refused,
   output logic protect_violation_flag,
   // interrupt
   output logic flash_irq
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] flash_protection_reg;
   logic buf_ie_reg;
   logic done_ie_reg;
   logic key_access_reg;
   logic viol_reg;
   logic [FPC_EVT_W-1:0] evt_stat_reg;
   logic [FPC_EVT_W-1:0] evt_mask_reg;
   logic buf_empty_d_reg;
   logic cmd_done_d_reg;
   logic aw_have_reg;
   logic w_have_reg;
   logic [11:0] aw_addr_reg;
   logic [7:0] w_data_reg;
   logic w_lane0_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic cmd_wr_reg;
   logic key_wr_reg;
   logic rd_go_reg;
   logic cmd_ok_reg;
   logic cmd_ref_reg;
   logic irq_reg;

   logic wr_go;
   logic rd_go;
   logic prot_hit;
   logic prot_any;
   logic grow_ok;
   logic refuse_now;
   logic [FPC_EVT_W-1:0] evt_set;
   logic [7:0] prot_wdata;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // protected kbytes of the lower range; reserved codes count as whole array
   function automatic logic [5:0] lo_size(input logic [2:0] code);
      case (code)
         3'h3: lo_size = 6'h04;
         3'h4: lo_size = 6'h03;
         3'h5: lo_size = 6'h02;
         3'h6: lo_size = 6'h01;
         3'h7: lo_size = 6'h00;
         default: lo_size = 6'h20;
      endcase
   endfunction

   // a mapped register answers with okay, any other address with slverr
   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == FPC_PROT_OFS) || (a == FPC_CFG_OFS) || (a == FPC_STAT_OFS) ||
               (a == FPC_IRQ_STAT_OFS) || (a == FPC_IRQ_MASK_OFS);
   endfunction

   // ----------------------------------------
   // protection decode
   // ----------------------------------------
   fpc_prot_check u_check (
      .prot(flash_protection_reg),
      .addr(cmd_addr),
      .hit(prot_hit),
      .any_prot(prot_any)
   );

   assign prot_wdata = w_data_reg;
   // each field may only widen: higher start must not rise, lower size not fall
   assign grow_ok = (prot_wdata[FPC_HI_MSB:FPC_HI_LSB] <= flash_protection_reg[FPC_HI_MSB:FPC_HI_LSB]) &&
                    (lo_size(prot_wdata[FPC_LO_MSB:FPC_LO_LSB]) >=
                     lo_size(flash_protection_reg[FPC_LO_MSB:FPC_LO_LSB]));
   assign refuse_now = cmd_req && (cmd_mass ? prot_any : prot_hit);

   // ----------------------------------------
   // bus write channel
   // ----------------------------------------
   assign wr_go = aw_have_reg && w_have_reg && !bvalid_reg;

   // address and data are caught independently, in either order
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         awready_reg <= 1'b0;
      end else if (s_axi_awvalid && awready_reg) begin
         aw_have_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
         awready_reg <= 1'b0;
      end else if (wr_go) begin
         aw_have_reg <= 1'b0;
      end else if (!aw_have_reg && !bvalid_reg) begin
         awready_reg <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         w_have_reg <= 1'b0;
         w_data_reg <= 8'h00;
         w_lane0_reg <= 1'b0;
         wready_reg <= 1'b0;
      end else if (s_axi_wvalid && wready_reg) begin
         w_have_reg <= 1'b1;
         w_data_reg <= s_axi_wdata[7:0];
         w_lane0_reg <= s_axi_wstrb[0];
         wready_reg <= 1'b0;
      end else if (wr_go) begin
         w_have_reg <= 1'b0;
      end else if (!w_have_reg && !bvalid_reg) begin
         wready_reg <= 1'b1;
      end
   end

   // response after both halves are in hand
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= FPC_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= mapped(aw_addr_reg) ? FPC_RESP_OKAY : FPC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // bus read channel
   // ----------------------------------------
   assign rd_go = s_axi_arvalid && arready_reg;

   // unused register bits and the upper word read as zero
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= FPC_RESP_OKAY;
      end else if (rd_go) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= mapped(s_axi_araddr) ? FPC_RESP_OKAY : FPC_RESP_SLVERR;
         case (s_axi_araddr)
            FPC_PROT_OFS: rdata_reg <= {24'h000000, flash_protection_reg};
            FPC_CFG_OFS: rdata_reg <= {24'h000000, buf_ie_reg, done_ie_reg, key_access_reg, 5'h00};
            FPC_STAT_OFS: rdata_reg <= {24'h000000, 2'h0, viol_reg, 5'h00};
            FPC_IRQ_STAT_OFS: rdata_reg <= {29'h00000000, evt_stat_reg};
            FPC_IRQ_MASK_OFS: rdata_reg <= {29'h00000000, evt_mask_reg};
            default: rdata_reg <= 32'h0000_0000;
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end else if (!rvalid_reg) begin
         arready_reg <= 1'b1;
      end
   end

   // ----------------------------------------
   // protection register
   // ----------------------------------------
   // reset takes the stored byte; writes obey the mode
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         flash_protection_reg <= nvm_prot_byte;
      end else if (wr_go && w_lane0_reg && aw_addr_reg == FPC_PROT_OFS) begin
         if (special_mode) begin
            flash_protection_reg <= prot_wdata;
         end else if (grow_ok) begin
            flash_protection_reg <= prot_wdata;
         end
      end
   end

   // ----------------------------------------
   // configuration register
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         buf_ie_reg <= FPC_CFG_RST[FPC_CFG_BUF_IE_BIT];
         done_ie_reg <= FPC_CFG_RST[FPC_CFG_DONE_IE_BIT];
         key_access_reg <= FPC_CFG_RST[FPC_CFG_KEY_BIT];
      end else if (wr_go && w_lane0_reg && aw_addr_reg == FPC_CFG_OFS) begin
         buf_ie_reg <= w_data_reg[FPC_CFG_BUF_IE_BIT];
         done_ie_reg <= w_data_reg[FPC_CFG_DONE_IE_BIT];
         if (backdoor_enable_field == FPC_KEY_ENABLED) begin
            key_access_reg <= w_data_reg[FPC_CFG_KEY_BIT];
         end
      end
   end

   // ----------------------------------------
   // array access routing
   // ----------------------------------------
   // reads never wait on the key bit, so key entry cannot stall fetches
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cmd_wr_reg <= 1'b0;
         key_wr_reg <= 1'b0;
         rd_go_reg <= 1'b0;
      end else begin
         cmd_wr_reg <= flash_wr_valid && !key_access_reg;
         key_wr_reg <= flash_wr_valid && key_access_reg;
         rd_go_reg <= flash_rd_req;
      end
   end

   // ----------------------------------------
   // program and erase gate
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cmd_ok_reg <= 1'b0;
         cmd_ref_reg <= 1'b0;
      end else begin
         cmd_ok_reg <= cmd_req && !refuse_now;
         cmd_ref_reg <= refuse_now;
      end
   end

   // violation flag: write one to clear, a new refusal wins over the clear
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         viol_reg <= 1'b0;
      end else if (refuse_now) begin
         viol_reg <= 1'b1;
      end else if (wr_go && w_lane0_reg && aw_addr_reg == FPC_STAT_OFS && w_data_reg[FPC_STAT_VIOL_BIT]) begin
         viol_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // interrupts
   // ----------------------------------------
   assign evt_set = {refuse_now, cmd_done_flag && !cmd_done_d_reg, buf_empty_flag && !buf_empty_d_reg};

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         buf_empty_d_reg <= 1'b0;
         cmd_done_d_reg <= 1'b0;
      end else begin
         buf_empty_d_reg <= buf_empty_flag;
         cmd_done_d_reg <= cmd_done_flag;
      end
   end

   // sticky events, cleared by reading; an event in the read cycle survives
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         evt_stat_reg <= '0;
      end else if (rd_go && s_axi_araddr == FPC_IRQ_STAT_OFS) begin
         evt_stat_reg <= evt_set;
      end else begin
         evt_stat_reg <= evt_stat_reg | evt_set;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         evt_mask_reg <= FPC_MASK_RST;
      end else if (wr_go && w_lane0_reg && aw_addr_reg == FPC_IRQ_MASK_OFS) begin
         evt_mask_reg <= w_data_reg[FPC_EVT_W-1:0];
      end
   end

   // level flags feed the line directly through their enables
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= (buf_ie_reg && buf_empty_flag) ||
                    (done_ie_reg && cmd_done_flag) ||
                    (|(evt_stat_reg & evt_mask_reg));
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign cmd_wr_pulse = cmd_wr_reg;
   assign key_wr_pulse = key_wr_reg;
   assign flash_rd_go = rd_go_reg;
   assign cmd_ok = cmd_ok_reg;
   assign cmd_refused = cmd_ref_reg;
   assign protect_violation_flag = viol_reg;
   assign flash_irq = irq_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence refuse_s;
      cmd_refused && !cmd_ok ##0 protect_violation_flag;
   endsequence

   sequence prot_wr_s;
      wr_go && w_lane0_reg && aw_addr_reg == FPC_PROT_OFS;
   endsequence

   buf_irq_a: assert property (buf_ie_reg && buf_empty_flag |=> flash_irq)
      else $error("buffer empty interrupt missing");
   done_irq_a: assert property (done_ie_reg && cmd_done_flag |=> flash_irq)
      else $error("command done interrupt missing");
   key_route_a: assert property (flash_wr_valid |=> (key_wr_pulse == $past(key_access_reg)) && (cmd_wr_pulse != key_wr_pulse))
      else $error("array write routed wrongly");
   prot_shrink_a: assert property (prot_wr_s and !special_mode && !grow_ok |=> $stable(flash_protection_reg))
      else $error("shrinking protection write taken");
   prot_free_a: assert property (prot_wr_s and special_mode |=> flash_protection_reg == $past(w_data_reg))
      else $error("special mode protection write lost");
   viol_set_a: assert property (cmd_req && !cmd_mass && prot_hit |=> refuse_s)
      else $error("protected program not refused");
   mass_ref_a: assert property (cmd_req && cmd_mass |=> (cmd_refused == $past(prot_any)) && (cmd_ok == !$past(prot_any)))
      else $error("mass erase gate wrong");
   key_lock_a: assert property (backdoor_enable_field != FPC_KEY_ENABLED && !sys_rst |=> $stable(key_access_reg))
      else $error("key bit changed while locked");
   rd_serve_a: assert property (flash_rd_req |=> flash_rd_go)
      else $error("array read not served");

endmodule
